// ### aod_chk.sv
// assertion checker for the overrange detector top
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// checker: shadows settings from register writes
module aod_chk (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // register port
  input wire logic [2:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  // converter results
  input wire logic [11:0] conv_a_rise,
  input wire logic [11:0] conv_a_fall,
  input wire logic [11:0] conv_b_rise,
  input wire logic [11:0] conv_b_fall,
  // pins, stream and bookkeeping
  input wire logic chan_a_high_flag,
  input wire logic chan_a_low_flag,
  input wire logic chan_b_high_flag,
  input wire logic chan_b_low_flag,
  input wire logic out_valid,
  input wire logic out_ready,
  input wire aod_pkg::aod_word_t out_data,
  input wire logic cal_busy,
  input wire logic [2:0] core_index
);
  logic [15:0] ctrl;
  logic [15:0] thr;
  logic [2:0] hold;
  logic [11:0] smp_a;
  logic [11:0] smp_b;
  logic smp_ok;
  logic [10:0] cnt [4];
  logic [8:0] busy_n;
  // magnitude top bits, most negative code saturates
  function automatic logic [7:0] mag8(input logic [11:0] ob);
    logic [11:0] m;
    m = ob[11] ? {1'b0, ob[10:0]} : 12'h800 - ob;
    mag8 = m[11] ? 8'hFF : m[10:3];
  endfunction
  // slot selection, events and hold length
  wire logic sgl = ctrl[aod_pkg::SINGLE_BIT];
  wire logic selb = ctrl[aod_pkg::INPUT_B_BIT];
  wire logic [11:0] slot_a = sgl && selb ? conv_b_rise : conv_a_rise;
  wire logic [11:0] slot_b = !sgl ? conv_b_rise : (selb ? conv_b_fall : conv_a_fall);
  wire logic [7:0] ma = mag8(smp_a);
  wire logic [7:0] mb = mag8(smp_b);
  wire logic [3:0] ev = {4{smp_ok}} & {mb >= thr[15:8], mb >= thr[7:0], ma >= thr[15:8],
    ma >= thr[7:0]};
  wire logic [3:0] flag = {chan_b_low_flag, chan_b_high_flag, chan_a_low_flag, chan_a_high_flag};
  wire logic [10:0] len = aod_pkg::HOLD_BASE << hold;
  // expected core pointer one step on, wrapping at six
  wire logic [3:0] core_nx = {1'b0, core_index} + (sgl ? 4'h2 : 4'h1);
  wire logic [2:0] core_exp = core_nx >= {1'b0, aod_pkg::CORE_COUNT} ?
    core_nx[2:0] - aod_pkg::CORE_COUNT : core_nx[2:0];
  // shadow state; hold counters restart on every event
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      ctrl <= aod_pkg::CTRL_RESET;
      thr <= {aod_pkg::LOW_LEVEL_RESET, aod_pkg::NEAR_FULL_RESET};
      hold <= aod_pkg::HOLD_RESET;
      smp_ok <= 1'b0;
      smp_a <= 12'h800;
      smp_b <= 12'h800;
      busy_n <= 9'h000;
      for (int i = 0; i < 4; i++)
        cnt[i] <= 11'h000;
    end
    else
    begin
      if (reg_wr && reg_addr == aod_pkg::CTRL_ADDR)
        ctrl <= reg_wdata;
      if (reg_wr && reg_addr == aod_pkg::THRESH_ADDR)
        thr <= reg_wdata;
      if (reg_wr && reg_addr == aod_pkg::HOLD_ADDR)
        hold <= reg_wdata[2:0];
      smp_ok <= !cal_busy;
      smp_a <= slot_a;
      smp_b <= slot_b;
      busy_n <= cal_busy ? busy_n + 9'h001 : 9'h000;
      for (int i = 0; i < 4; i++)
        cnt[i] <= ev[i] ? len : (cnt[i] != 11'h000 ? cnt[i] - 11'h001 : cnt[i]);
    end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence cal_wr_s;
    reg_wr && reg_addr == aod_pkg::CAL_ADDR && reg_wdata[0] && !cal_busy;
  endsequence
  sequence cal_run_s;
    cal_busy [*8];
  endsequence
  // ============================================================
  // pins follow events for exactly the hold length
  a_high_hold_a:
    assert property (chan_a_high_flag == (cnt[0] != 11'h000)) else $error("a high pin");
  a_low_hold_a:
    assert property (chan_a_low_flag == (cnt[1] != 11'h000)) else $error("a low pin");
  b_high_hold_a:
    assert property (chan_b_high_flag == (cnt[2] != 11'h000)) else $error("b high pin");
  b_low_hold_a:
    assert property (chan_b_low_flag == (cnt[3] != 11'h000)) else $error("b low pin");
  cal_start_a:
    assert property (cal_wr_s |=> cal_run_s) else $error("calibration not started");
  cal_len_a:
    assert property ($fell(cal_busy) |-> busy_n == 9'h0FF) else $error("calibration length");
  core_range_a:
    assert property (core_index < aod_pkg::CORE_COUNT) else $error("core pointer range");
  core_step_a:
    assert property (rst_b && (!cal_busy || ctrl[aod_pkg::BG_CAL_BIT]) |=>
      core_index == $past(core_exp)) else $error("core rotation");
  rdata_idle_a:
    assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000) else $error("read data idle");
  status_pins_a:
    assert property (reg_rd && reg_addr == aod_pkg::STATUS_ADDR |=>
      reg_rdata[3:0] == $past(flag) && reg_rdata[4] == $past(cal_busy)) else $error("status");
  out_hold_a:
    assert property (out_valid && !out_ready |=> out_valid && $stable(out_data))
    else $error("stream head moved");
endmodule
bind aod_top aod_chk u_chk (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .conv_a_rise(conv_a_rise), .conv_a_fall(conv_a_fall), .conv_b_rise(conv_b_rise),
  .conv_b_fall(conv_b_fall), .chan_a_high_flag(chan_a_high_flag),
  .chan_a_low_flag(chan_a_low_flag), .chan_b_high_flag(chan_b_high_flag),
  .chan_b_low_flag(chan_b_low_flag), .out_valid(out_valid), .out_ready(out_ready),
  .out_data(out_data), .cal_busy(cal_busy), .core_index(core_index));
`default_nettype wire

// ### aod_pkg.sv
// constants, types and register map of the overrange detector block
// Function
// - dual mode rising edge, single both edges
// - samples coded in two's complement
// - codes span -2048 to +2047
// - magnitude upper 8 bits against two thresholds
// - same thresholds for both channels
// - 11-bit magnitude, most negative saturates 2047
// - flag set when magnitude reaches threshold
// - two flag pins per channel
// - single mode spreads thresholds over both pins
// - flag hold 8 doubling to 1024 cycles
// - embed flags only in decimating formats
// - complex: I carries high, Q carries low
// - real: even high flag, odd low flag
// - monitor period depends on format type
// - six interleaved cores swapped for calibration
// - calibration halts sampling in both modes, background keeps cores rotating
// - single mode samples selected analog input
package aod_pkg;
  // ==========================================================
  // register bus
  localparam int ADDR_W = 3;
  localparam int DATA_W = 16;
  localparam logic [2:0] CTRL_ADDR = 3'h0;
  localparam logic [2:0] THRESH_ADDR = 3'h1;
  localparam logic [2:0] HOLD_ADDR = 3'h2;
  localparam logic [2:0] CAL_ADDR = 3'h3;
  localparam logic [2:0] STATUS_ADDR = 3'h4;
  // control field positions
  localparam int SINGLE_BIT = 0;
  localparam int INPUT_B_BIT = 1;
  localparam int BG_CAL_BIT = 2;
  localparam int FMT_LSB = 4;
  localparam int CAL_START_BIT = 0;
  // status field positions
  localparam int ST_FLAG_LSB = 0;
  localparam int ST_BUSY_BIT = 4;
  localparam int ST_OVF_BIT = 5;
  localparam int ST_CORE_LSB = 8;
  // reset values
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [7:0] NEAR_FULL_RESET = 8'hE4;
  localparam logic [7:0] LOW_LEVEL_RESET = 8'h40;
  localparam logic [2:0] HOLD_RESET = 3'h0;
  // ==========================================================
  // converter and link formats
  localparam int SAMPLE_W = 12;
  localparam int WORD_W = 16;
  localparam logic [3:0] FMT_REAL = 4'h9;
  localparam logic [3:0] FMT_CPLX_LO = 4'hA;
  localparam logic [3:0] FMT_CPLX_SKIP = 4'hC;
  localparam logic [3:0] FMT_CPLX_HI = 4'hF;
  localparam logic [2:0] CORE_COUNT = 3'h6;
  localparam logic [10:0] HOLD_BASE = 11'h008;
  localparam logic [7:0] FG_CAL_CYCLES = 8'hFF;
  localparam int FIFO_DEPTH = 32;
  // ==========================================================
  // one output beat: a channel A word and a channel B word
  typedef struct packed {
    logic [15:0] b;
    logic [15:0] a;
  } aod_word_t;
endpackage

// ### aod_sink.sv
// far-side model: drains the stream and combines flag pins
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// sink; mode 0 ready, 1 stall, 2 random ready
module aod_sink (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // stream control and pins
  input wire logic [1:0] mode,
  output logic out_ready,
  input wire logic [3:0] flags,
  output logic any_high,
  output logic any_low
);
  integer seed = 81;
  integer r;
  // either pin of a pair means the threshold tripped
  assign any_high = flags[0] | flags[2];
  assign any_low = flags[1] | flags[3];
  // ready moves only just after an edge
  always @(posedge clk or negedge rst_b)
    if (!rst_b)
      out_ready <= 1'b0;
    else
    begin
      r = $random(seed);
      out_ready <= mode == 2'h0 || (mode == 2'h2 && r[0]);
    end
endmodule
`default_nettype wire

// ### aod_top.sv
// overrange detector, sample formatter and output fifo
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// shift fifo: head entry is a flop so the output needs no mux
module aod_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 32
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int CW = $clog2(DEPTH + 1);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [CW-1:0] count;
  logic [CW-1:0] next_count;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  wire [CW-1:0] wr_idx = pop ? count - CW'(1) : count;

  // occupancy after this cycle
  always_comb
  begin
    next_count = count;
    if (push && !pop)
    begin
      next_count = count + CW'(1);
    end
    else if (pop && !push)
    begin
      next_count = count - CW'(1);
    end
  end

  // flags are registered from the next count, so they are honest
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      count <= '0;
      out_valid <= 1'b0;
      in_ready <= 1'b1;
    end
    else
    begin
      count <= next_count;
      out_valid <= next_count != '0;
      in_ready <= next_count != CW'(DEPTH);
    end
  end

  // shift down on pop, write at the tail
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      for (int i = 0; i < DEPTH; i++)
      begin
        mem[i] <= '0;
      end
    end
    else
    begin
      for (int i = 0; i < DEPTH; i++)
      begin
        if (push && CW'(i) == wr_idx)
        begin
          mem[i] <= in_data;
        end
        else if (pop && i < DEPTH - 1)
        begin
          mem[i] <= mem[i + 1];
        end
      end
    end
  end

  assign out_data = mem[0];
endmodule

// ============================================================
// top of the block
module aod_top (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // register port
  input wire logic [2:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // raw converter results, offset binary, per analog input and edge
  input wire logic [11:0] conv_a_rise,
  input wire logic [11:0] conv_a_fall,
  input wire logic [11:0] conv_b_rise,
  input wire logic [11:0] conv_b_fall,
  // overrange flag pins
  output logic chan_a_high_flag,
  output logic chan_a_low_flag,
  output logic chan_b_high_flag,
  output logic chan_b_low_flag,
  // output sample stream
  output logic out_valid,
  input wire logic out_ready,
  output aod_pkg::aod_word_t out_data,
  // core bookkeeping
  output logic cal_busy,
  output logic [2:0] core_index
);
  // ==========================================================
  // helper functions
  // offset binary to two's complement: flip the sign bit
  function automatic logic [11:0] to_signed(input logic [11:0] raw);
    to_signed = {~raw[11], raw[10:0]};
  endfunction

  // 11-bit magnitude, upper 8 bits; -2048 saturates to 2047
  function automatic logic [7:0] mag8(input logic [11:0] s);
    logic [11:0] neg;
    logic [10:0] m;
    neg = ~s + 12'h001;
    m = s[11] ? neg[10:0] : s[10:0];
    if (s == 12'h800) m = 11'h7FF;
    mag8 = m[10:3];
  endfunction

  // ==========================================================
  // registers
  logic [15:0] ctrl;
  logic [7:0] near_full_threshold;
  logic [7:0] low_level_threshold;
  logic [2:0] overrange_hold_select;
  logic overflow;
  logic [7:0] cal_count;

  wire single_mode = ctrl[aod_pkg::SINGLE_BIT];
  wire single_input_b = ctrl[aod_pkg::INPUT_B_BIT];
  wire bg_cal_en = ctrl[aod_pkg::BG_CAL_BIT];
  wire [3:0] link_format_select = ctrl[aod_pkg::FMT_LSB +: 4];
  wire wr_ctrl = reg_wr && reg_addr == aod_pkg::CTRL_ADDR;
  wire wr_thresh = reg_wr && reg_addr == aod_pkg::THRESH_ADDR;
  wire wr_hold = reg_wr && reg_addr == aod_pkg::HOLD_ADDR;
  wire wr_cal = reg_wr && reg_addr == aod_pkg::CAL_ADDR;
  wire rd_status = reg_rd && reg_addr == aod_pkg::STATUS_ADDR;
  wire cal_start = wr_cal && reg_wdata[aod_pkg::CAL_START_BIT];

  // software settings; thresholds are 8-bit unsigned
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ctrl <= aod_pkg::CTRL_RESET;
      near_full_threshold <= aod_pkg::NEAR_FULL_RESET;
      low_level_threshold <= aod_pkg::LOW_LEVEL_RESET;
      overrange_hold_select <= aod_pkg::HOLD_RESET;
    end
    else
    begin
      if (wr_ctrl) ctrl <= reg_wdata;
      if (wr_thresh) near_full_threshold <= reg_wdata[7:0];
      if (wr_thresh) low_level_threshold <= reg_wdata[15:8];
      if (wr_hold) overrange_hold_select <= reg_wdata[2:0];
    end
  end

  // read data valid the cycle after the strobe only
  wire [15:0] status_word = {5'h00, core_index, 2'h0, overflow, cal_busy,
    chan_b_low_flag, chan_b_high_flag, chan_a_low_flag, chan_a_high_flag};
  wire [15:0] rd_mux =
    !reg_rd ? 16'h0000 :
    reg_addr == aod_pkg::CTRL_ADDR ? ctrl :
    reg_addr == aod_pkg::THRESH_ADDR ? {low_level_threshold, near_full_threshold} :
    reg_addr == aod_pkg::HOLD_ADDR ? {13'h0000, overrange_hold_select} :
    reg_addr == aod_pkg::STATUS_ADDR ? status_word : 16'h0000;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b) reg_rdata <= 16'h0000;
    else reg_rdata <= rd_mux;
  end

  // ==========================================================
  // calibration and core rotation
  // foreground run stops sampling for a fixed time
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cal_count <= 8'h00;
      cal_busy <= 1'b0;
    end
    else
    begin
      if (cal_start) cal_count <= aod_pkg::FG_CAL_CYCLES;
      else if (cal_count != 8'h00) cal_count <= cal_count - 8'h01;
      cal_busy <= cal_start || cal_count > 8'h01;
    end
  end

  // six cores take turns; two per clock when both edges sample
  wire [2:0] core_step = single_mode ? 3'h2 : 3'h1;
  wire [3:0] core_sum = {1'b0, core_index} + {1'b0, core_step};
  wire [3:0] core_wrap = core_sum - {1'b0, aod_pkg::CORE_COUNT};
  wire [2:0] next_core =
    core_sum >= {1'b0, aod_pkg::CORE_COUNT} ? core_wrap[2:0] : core_sum[2:0];
  // background calibration keeps the cores rotating, but sampling still stops while busy
  wire sampling = !cal_busy;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b) core_index <= 3'h0;
    else if (sampling || bg_cal_en) core_index <= next_core;
  end

  // ==========================================================
  // sample capture
  // dual: each input on the rising edge; single: one input, both edges
  wire [11:0] sel_rise = single_input_b ? conv_b_rise : conv_a_rise;
  wire [11:0] sel_fall = single_input_b ? conv_b_fall : conv_a_fall;
  wire [11:0] slot_a_raw = single_mode ? sel_rise : conv_a_rise;
  wire [11:0] slot_b_raw = single_mode ? sel_fall : conv_b_rise;
  logic [11:0] samp_a;
  logic [11:0] samp_b;
  logic samp_valid;

  // full 12-bit signed range, no clipping beyond -2048..+2047
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      samp_a <= 12'h000;
      samp_b <= 12'h000;
      samp_valid <= 1'b0;
    end
    else
    begin
      samp_a <= to_signed(slot_a_raw);
      samp_b <= to_signed(slot_b_raw);
      samp_valid <= sampling;
    end
  end

  // ==========================================================
  // threshold compare, same pair for both slots
  wire [7:0] mag_a = mag8(samp_a);
  wire [7:0] mag_b = mag8(samp_b);
  // event order: a_high, a_low, b_high, b_low
  wire [3:0] evt = samp_valid ? {
    mag_b >= low_level_threshold, mag_b >= near_full_threshold,
    mag_a >= low_level_threshold, mag_a >= near_full_threshold} : 4'h0;

  // ==========================================================
  // pin hold counters, restarted by every new event
  wire [10:0] hold_len = aod_pkg::HOLD_BASE << overrange_hold_select;
  logic [10:0] hold_cnt [4];
  logic [3:0] pin_flag;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      for (int i = 0; i < 4; i++) hold_cnt[i] <= 11'h000;
      pin_flag <= 4'h0;
    end
    else
    begin
      for (int i = 0; i < 4; i++)
      begin
        if (evt[i]) hold_cnt[i] <= hold_len - 11'h001;
        else if (hold_cnt[i] != 11'h000) hold_cnt[i] <= hold_cnt[i] - 11'h001;
        pin_flag[i] <= evt[i] || hold_cnt[i] != 11'h000;
      end
    end
  end

  // single mode: slot a and slot b pins split each threshold
  assign chan_a_high_flag = pin_flag[0];
  assign chan_a_low_flag = pin_flag[1];
  assign chan_b_high_flag = pin_flag[2];
  assign chan_b_low_flag = pin_flag[3];

  // ==========================================================
  // embedded status over the monitoring period
  wire fmt_real = link_format_select == aod_pkg::FMT_REAL;
  wire fmt_cplx = link_format_select >= aod_pkg::FMT_CPLX_LO &&
    link_format_select <= aod_pkg::FMT_CPLX_HI &&
    link_format_select != aod_pkg::FMT_CPLX_SKIP;
  wire embed_on = fmt_real || fmt_cplx;
  // real counts one more doubling than complex
  wire [3:0] period_exp = fmt_real ? {1'b0, overrange_hold_select} + 4'h1 :
    {1'b0, overrange_hold_select};
  wire [8:0] period = 9'h001 << period_exp;
  logic [8:0] mon_cnt;
  logic [3:0] mon_acc;
  logic [3:0] embed;
  logic word_odd;
  wire mon_end = mon_cnt >= period - 9'h001;

  // accumulate events, latch at each period end
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      mon_cnt <= 9'h000;
      mon_acc <= 4'h0;
      embed <= 4'h0;
      word_odd <= 1'b0;
    end
    else if (samp_valid)
    begin
      mon_cnt <= mon_end ? 9'h000 : mon_cnt + 9'h001;
      mon_acc <= mon_end ? 4'h0 : mon_acc | evt;
      if (mon_end) embed <= mon_acc | evt;
      word_odd <= !word_odd;
    end
  end

  // even word (or I) carries high flag, odd word (or Q) low flag
  function automatic logic [15:0] pack(input logic [11:0] s,
    input logic on, input logic odd, input logic hi, input logic lo);
    pack = {s, 4'h0};
    if (on) pack[0] = odd ? lo : hi;
  endfunction

  aod_pkg::aod_word_t beat;
  assign beat.a = pack(samp_a, embed_on, word_odd, embed[0], embed[1]);
  assign beat.b = pack(samp_b, embed_on, word_odd, embed[2], embed[3]);

  // ==========================================================
  // output fifo; a full fifo drops the beat and marks overflow
  logic fifo_ready;
  wire drop = samp_valid && !fifo_ready;

  // set beats the read clear
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b) overflow <= 1'b0;
    else if (drop) overflow <= 1'b1;
    else if (rd_status) overflow <= 1'b0;
  end

  aod_fifo #(
    .WIDTH(32),
    .DEPTH(aod_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst_b(rst_b),
    .in_valid(samp_valid),
    .in_ready(fifo_ready),
    .in_data(beat),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_data(out_data)
  );
endmodule

`default_nettype wire

// ### tb.sv
// testbench: registers, flag pins and sample stream of aod_top
`timescale 1ns/1ps
`default_nettype none
// ============================================================
module tb;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic [11:0] c_ar = 12'h800, c_af = 12'h800, c_br = 12'h800, c_bf = 12'h800;
  logic [11:0] sa, sb;
  logic [3:0] flags;
  logic out_valid, out_ready, cal_busy, any_high, any_low;
  aod_pkg::aod_word_t out_data;
  logic [2:0] core_index;
  logic [1:0] mode = 2'h0;
  logic rnd_on = 1'b0;
  logic pend_ok = 1'b0;
  logic [15:0] ctrl_m, d;
  logic [31:0] pend;
  logic [31:0] q [$];
  logic [31:0] w;
  logic [15:0] thr_m;
  logic [2:0] hold_m;
  logic [3:0] m_acc, m_emb, ev, f;
  logic m_odd;
  logic [15:0] cv [6] = '{16'h0000, 16'h0001, 16'h0003, 16'h0001, 16'h0090, 16'h00D0};
  logic [11:0] tv [6] = '{12'hFFF, 12'hFF0, 12'h800, 12'h010, 12'h000, 12'hFEF};
  logic [1:0] te [6] = '{2'h3, 2'h1, 2'h0, 2'h1, 2'h3, 2'h0};
  integer n_errors = 0, compares = 0, cyc = 0, seed = 81, rv, i, n, per, m_cnt;
  always #25 clk = ~clk;
  aod_top u_dut (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .conv_a_rise(c_ar),
    .conv_a_fall(c_af), .conv_b_rise(c_br), .conv_b_fall(c_bf),
    .chan_a_high_flag(flags[0]), .chan_a_low_flag(flags[1]), .chan_b_high_flag(flags[2]),
    .chan_b_low_flag(flags[3]), .out_valid(out_valid), .out_ready(out_ready),
    .out_data(out_data), .cal_busy(cal_busy), .core_index(core_index));
  aod_sink u_sink (.clk(clk), .rst_b(rst_b), .mode(mode), .out_ready(out_ready),
    .flags(flags), .any_high(any_high), .any_low(any_low));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [15:0] v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [15:0] v);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    // read data stand for one cycle only, so take them mid-cycle
    @(negedge clk);
    v = reg_rdata;
  endtask
  // one loud sample on both channels, then quiet again
  task automatic hot(input logic [11:0] v);
    @(posedge clk);
    c_ar <= v;
    c_br <= v;
    @(posedge clk);
    c_ar <= 12'h800;
    c_br <= 12'h800;
  endtask
  // magnitude top bits of a signed code, -2048 clipped to 2047
  function automatic integer mg(input logic [11:0] s);
    integer v;
    v = $signed(s);
    if (v < 0)
      v = -v;
    if (v > 2047)
      v = 2047;
    return v >> 3;
  endfunction
  task automatic finish_test;
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // random codes; started after the fixed drives and never stopped
  always @(posedge clk)
    if (rnd_on)
    begin
      rv = $random(seed);
      c_ar <= rv[11:0];
      c_af <= rv[23:12];
      rv = $random(seed);
      c_br <= rv[11:0];
      c_bf <= rv[23:12];
    end
  // reference stream: capture, one stage, fifo capped at depth
  always @(posedge clk)
    if (!rst_b)
    begin
      q.delete();
      pend_ok <= 1'b0;
      ctrl_m <= 16'h0000;
      thr_m <= {aod_pkg::LOW_LEVEL_RESET, aod_pkg::NEAR_FULL_RESET};
      hold_m <= aod_pkg::HOLD_RESET;
      m_cnt = 0;
      m_acc = 4'h0;
      m_emb = 4'h0;
      m_odd = 1'b0;
    end
    else
    begin
      // push before pop: a full fifo refuses even when it drains this edge
      if (pend_ok)
      begin
        w = pend;
        f = ctrl_m[7:4];
        if (f == aod_pkg::FMT_REAL || (f >= aod_pkg::FMT_CPLX_LO && f != aod_pkg::FMT_CPLX_SKIP))
        begin
          w[0] = m_odd ? m_emb[1] : m_emb[0];
          w[16] = m_odd ? m_emb[3] : m_emb[2];
        end
        if (q.size() < aod_pkg::FIFO_DEPTH)
          q.push_back(w);
        ev = {mg(pend[31:20]) >= thr_m[15:8], mg(pend[31:20]) >= thr_m[7:0],
          mg(pend[15:4]) >= thr_m[15:8], mg(pend[15:4]) >= thr_m[7:0]};
        per = (f == aod_pkg::FMT_REAL ? 2 : 1) << hold_m;
        m_acc = m_acc | ev;
        if (m_cnt >= per - 1)
        begin
          m_emb = m_acc;
          m_acc = 4'h0;
          m_cnt = 0;
        end
        else
          m_cnt++;
        m_odd = !m_odd;
      end
      if (out_valid && out_ready)
        chk(out_data, q.pop_front());
      sa = ctrl_m[0] && ctrl_m[1] ? c_br : c_ar;
      sb = !ctrl_m[0] ? c_br : (ctrl_m[1] ? c_bf : c_af);
      pend <= {sb ^ 12'h800, 4'h0, sa ^ 12'h800, 4'h0};
      pend_ok <= !cal_busy;
      if (reg_wr && reg_addr == aod_pkg::CTRL_ADDR)
        ctrl_m <= reg_wdata;
      if (reg_wr && reg_addr == aod_pkg::THRESH_ADDR)
        thr_m <= reg_wdata;
      if (reg_wr && reg_addr == aod_pkg::HOLD_ADDR)
        hold_m <= reg_wdata[2:0];
    end
  // hang guard, far above the expected run length
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_errors++;
      finish_test;
    end
  end
  // ============================================================
  // main sequence
  initial
  begin
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    wr(aod_pkg::STATUS_ADDR, 16'hFFFF);
    wr(3'h7, 16'hFFFF);
    for (i = 0; i < 8; i++)
    begin
      rd(i[2:0], d);
      chk({16'h0, d & (i == 4 ? 16'h00FF : 16'hFFFF)}, i == 1 ? 32'h40E4 : 32'h0);
    end
    wr(aod_pkg::THRESH_ADDR, 16'hFFFE);
    for (i = 0; i < 6; i++)
    begin
      hot(tv[i]);
      repeat (3) @(posedge clk);
      chk({26'h0, any_low, any_high, flags}, {26'h0, te[i], te[i], te[i]});
      repeat (12) @(posedge clk);
    end
    wr(aod_pkg::THRESH_ADDR, 16'h40E4);
    for (i = 0; i < 8; i++)
    begin
      wr(aod_pkg::HOLD_ADDR, i[15:0]);
      hot(12'h000);
      n = 0;
      repeat (2) @(posedge clk);
      while (any_high === 1'b1 && n < 2000)
      begin
        @(posedge clk);
        n++;
      end
      chk(n, 8 << i);
    end
    wr(aod_pkg::HOLD_ADDR, 16'h0003);
    rnd_on <= 1'b1;
    for (i = 0; i < 6; i++)
    begin
      wr(aod_pkg::CTRL_ADDR, cv[i]);
      mode <= i == 3 ? 2'h1 : 2'h2;
      repeat (i == 3 ? 50 : 20) @(posedge clk);
      wr(aod_pkg::CAL_ADDR, 16'h0001);
      mode <= 2'h0;
      rd(aod_pkg::STATUS_ADDR, d);
      chk(d[5:4], {i == 3, 1'b1});
      rd(aod_pkg::STATUS_ADDR, d);
      chk(d[5:4], 2'h1);
      repeat (60) @(posedge clk);
      chk(q.size(), 0);
      n = 0;
      while (cal_busy === 1'b1 && n < 400)
      begin
        @(posedge clk);
        n++;
      end
      chk(cal_busy, 1'b0);
    end
    finish_test;
  end
endmodule
`default_nettype wire
